// File: aswc_regs.vh
`ifndef ASWC_REGS_VH
`define ASWC_REGS_VH

`define ASWC_ADDR_W 17
`define ASWC_DATA_W 8
`define ASWC_CLK_PERIOD_NS 100
// slowest grade figures
`define ASWC_T_CYCLE_NS 12
`define ASWC_T_SEL_END_NS 9
`define ASWC_T_ADDR_END_NS 9
// least times round up, never below one cycle
`define ASWC_CYC(ns) ((((ns) + `ASWC_CLK_PERIOD_NS - 1) / `ASWC_CLK_PERIOD_NS) < 1 ? 1 : \
    (((ns) + `ASWC_CLK_PERIOD_NS - 1) / `ASWC_CLK_PERIOD_NS))
`define ASWC_CNT_W 4

`define ASWC_ST_IDLE 3'h0
`define ASWC_ST_SETUP 3'h1
`define ASWC_ST_STROBE 3'h2
`define ASWC_ST_RELEASE 3'h3
`define ASWC_ST_HOLD 3'h4

`endif

// File: aswc_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "aswc_regs.vh"
module aswc_timer (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_load,
    input wire [`ASWC_CNT_W-1:0] i_count,
    output wire o_done
);
    reg [`ASWC_CNT_W-1:0] cnt_r;
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 4'h0;
        end else if (i_load) begin
            cnt_r <= i_count;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    assign o_done = (cnt_r == 4'h0);
endmodule
`default_nettype wire

// File: aswc_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "aswc_regs.vh"
module aswc_ctrl (
    input wire I_CORE_CLK,
    input wire I_RST_N,
    input wire I_REQ,
    input wire [`ASWC_ADDR_W-1:0] I_ADDR,
    input wire [`ASWC_DATA_W-1:0] I_DATA,
    output reg O_BUSY,
    output reg O_DONE,
    output reg [`ASWC_ADDR_W-1:0] O_ADDR,
    output reg O_SEL_N,
    output reg O_WR_N,
    output reg O_OUT_EN_N,
    output reg [`ASWC_DATA_W-1:0] O_DATA_LINES,
    output reg O_DATA_LINES_OE
);
    localparam integer SEL_RAW = `ASWC_CYC(`ASWC_T_SEL_END_NS);
    localparam integer ADR_RAW = `ASWC_CYC(`ASWC_T_ADDR_END_NS);
    localparam integer CYC_RAW = `ASWC_CYC(`ASWC_T_CYCLE_NS);
    // counts are small, the timer width holds them
    localparam [`ASWC_CNT_W-1:0] SEL_CYC = SEL_RAW[`ASWC_CNT_W-1:0];
    localparam [`ASWC_CNT_W-1:0] ADR_CYC = ADR_RAW[`ASWC_CNT_W-1:0];
    localparam [`ASWC_CNT_W-1:0] CYC_CYC = CYC_RAW[`ASWC_CNT_W-1:0];
    localparam [`ASWC_CNT_W-1:0] STROBE_CYC = (SEL_CYC > ADR_CYC) ? SEL_CYC : ADR_CYC;

    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg load_nxt;
    reg [`ASWC_CNT_W-1:0] count_nxt;
    wire tmr_done;

    // ****************************************
    // interval timer
    // ****************************************
    aswc_timer u_timer (
        .i_clk(I_CORE_CLK),
        .i_rst_n(I_RST_N),
        .i_load(load_nxt),
        .i_count(count_nxt),
        .o_done(tmr_done)
    );

    // ****************************************
    // next state
    // ****************************************
    always @* begin
        state_nxt = state_r;
        load_nxt = 1'b0;
        count_nxt = 4'h0;
        case (state_r)
            `ASWC_ST_IDLE: begin
                if (I_REQ) begin
                    state_nxt = `ASWC_ST_SETUP;
                end
            end
            `ASWC_ST_SETUP: begin
                state_nxt = `ASWC_ST_STROBE;
                load_nxt = 1'b1;
                count_nxt = STROBE_CYC - 4'h1;
            end
            `ASWC_ST_STROBE: begin
                if (tmr_done) begin
                    state_nxt = `ASWC_ST_RELEASE;
                end
            end
            `ASWC_ST_RELEASE: begin
                state_nxt = `ASWC_ST_HOLD;
                load_nxt = 1'b1;
                count_nxt = CYC_CYC - 4'h1;
            end
            `ASWC_ST_HOLD: begin
                if (tmr_done) begin
                    state_nxt = `ASWC_ST_IDLE;
                end
            end
            default: begin
                state_nxt = `ASWC_ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // pin sequencing
    // ****************************************
    always @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_r <= `ASWC_ST_IDLE;
            O_BUSY <= 1'b0;
            O_DONE <= 1'b0;
            O_ADDR <= 17'h0_0000;
            O_SEL_N <= 1'b1;
            O_WR_N <= 1'b1;
            O_OUT_EN_N <= 1'b1;
            O_DATA_LINES <= 8'h00;
            O_DATA_LINES_OE <= 1'b0;
        end else begin
            state_r <= state_nxt;
            O_DONE <= 1'b0;
            case (state_r)
                `ASWC_ST_IDLE: begin
                    if (I_REQ) begin
                        // address and data set up with the write strobe, a cycle before select
                        O_BUSY <= 1'b1;
                        O_ADDR <= I_ADDR;
                        O_DATA_LINES <= I_DATA;
                        O_WR_N <= 1'b0;
                    end
                end
                `ASWC_ST_SETUP: begin
                    // memory outputs now off, safe to drive
                    O_SEL_N <= 1'b0;
                    O_DATA_LINES_OE <= 1'b1;
                end
                `ASWC_ST_STROBE: begin
                    if (tmr_done) begin
                        // select ends first, so outputs stay off
                        O_SEL_N <= 1'b1;
                    end
                end
                `ASWC_ST_RELEASE: begin
                    O_WR_N <= 1'b1;
                    O_DATA_LINES_OE <= 1'b0;
                end
                `ASWC_ST_HOLD: begin
                    // address untouched until cycle time met
                    if (tmr_done) begin
                        O_BUSY <= 1'b0;
                        O_DONE <= 1'b1;
                    end
                end
                default: begin
                    O_BUSY <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// File: aswc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "aswc_regs.vh"
module aswc_chk (
    input wire logic I_CORE_CLK,
    input wire logic I_RST_N,
    input wire logic O_DATA_LINES_OE,
    input wire logic [`ASWC_ADDR_W-1:0] O_ADDR,
    input wire logic O_SEL_N,
    input wire logic O_WR_N,
    input wire logic O_OUT_EN_N
);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RST_N);
    sequence s_sel_pulse;
        !O_SEL_N ##1 O_SEL_N;
    endsequence
    sequence s_walk;
        O_SEL_N ##1 (!O_SEL_N && O_DATA_LINES_OE) ##1 (O_SEL_N && !O_WR_N)
            ##1 (O_WR_N && !O_DATA_LINES_OE);
    endsequence
    a_write_walk: assert property ($fell(O_WR_N) |-> s_walk) else $error("write order");
    a_read_off: assert property (O_OUT_EN_N) else $error("output enable active");
    a_sel_after: assert property ($fell(O_SEL_N) |-> !$past(O_WR_N)) else $error("sel early");
    a_sel_in_wr: assert property (!O_SEL_N |-> !O_WR_N) else $error("select outside strobe");
    a_drive_in_wr: assert property (O_DATA_LINES_OE |-> !O_WR_N) else $error("data driven late");
    a_sel_width: assert property ($fell(O_SEL_N) |-> s_sel_pulse) else $error("select width");
    a_addr_hold: assert property ($changed(O_ADDR) |=> $stable(O_ADDR)) else $error("addr hold");
    a_addr_early: assert property ($rose(O_SEL_N) |-> $past(O_ADDR) == O_ADDR) else $error("addr late");
    a_addr_steady: assert property (!O_SEL_N |-> $stable(O_ADDR)) else $error("addr moved");
endmodule
bind aswc_ctrl aswc_chk u_chk (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
    .O_DATA_LINES_OE(O_DATA_LINES_OE), .O_ADDR(O_ADDR), .O_SEL_N(O_SEL_N), .O_WR_N(O_WR_N),
    .O_OUT_EN_N(O_OUT_EN_N));
`default_nettype wire

// File: aswc_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "aswc_regs.vh"
module aswc_sram (
    input wire logic i_sel_n,
    input wire logic i_wr_n,
    input wire logic i_out_en_n,
    input wire logic [`ASWC_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_dq,
    output logic o_q_en
);
    logic [7:0] store [0:131071];
    always @(i_sel_n or i_wr_n or i_addr or i_dq)
        if (!i_sel_n && !i_wr_n) store[i_addr] = i_dq;
    assign o_q_en = !i_sel_n && i_wr_n && !i_out_en_n;
endmodule
`default_nettype wire

// File: aswc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "aswc_regs.vh"
module aswc_ctrl_test;
    logic clk = 0, rst_n = 0, req = 0, clash = 0;
    logic [16:0] addr = 0;
    logic [7:0] data = 0;
    wire busy, done, sel_n, wr_n, oen, doe, q_en;
    wire [16:0] ma;
    wire [7:0] dq, bus;
    int errors = 0, comparisons = 0, cyc = 0;
    always #50 clk = ~clk;
    // undriven data lines show the inverse of the byte held on dq
    assign bus = doe ? dq : ~dq;
    aswc_ctrl dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_ADDR(addr), .I_DATA(data),
        .O_BUSY(busy), .O_DONE(done), .O_ADDR(ma), .O_SEL_N(sel_n), .O_WR_N(wr_n),
        .O_OUT_EN_N(oen), .O_DATA_LINES(dq), .O_DATA_LINES_OE(doe));
    aswc_sram mem (.i_sel_n(sel_n), .i_wr_n(wr_n), .i_out_en_n(oen), .i_addr(ma), .i_dq(bus),
        .o_q_en(q_en));
    always @(posedge clk) begin
        cyc++;
        if (q_en !== 1'b0 && doe) clash = 1;
        if (cyc == 2000) begin
            errors++;
            give_verdict;
        end
    end
    task check(string name, logic [7:0] exp, logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s exp %h got %h", name, exp, got);
        end
    endtask
    task give_verdict;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // called at a falling edge; returns at the falling edge of the done cycle
    task put(logic [16:0] a, logic [7:0] d);
        int n;
        req = 1;
        addr = a;
        data = d;
        @(negedge clk) req = 0;
        addr = ~a;
        data = ~d;
        check("busy", 1, busy);
        n = 1;
        while (done !== 1'b1 && n < 9) begin
            @(negedge clk);
            n++;
        end
        check("latency", 5, n[7:0]);
        check("idle", 0, busy);
        check("out_en_n", 1, oen);
    endtask
    task t_single;
        @(negedge clk) put(17'h1_2345, 8'ha5);
        check("word", 8'ha5, mem.store[17'h1_2345]);
        check("clash", 0, clash);
        @(negedge clk) check("pulse", 0, done);
        $display("single done");
    endtask
    task t_back;
        @(negedge clk) put(17'h0_0000, 8'h5a);
        put(17'h1_ffff, 8'hc3);
        check("low", 8'h5a, mem.store[17'h0_0000]);
        check("high", 8'hc3, mem.store[17'h1_ffff]);
        check("clash", 0, clash);
        $display("back done");
    endtask
    // reset pulled while select is low, then a fresh write
    task t_reset;
        @(negedge clk) req = 1;
        addr = 17'h0_0f0f;
        data = 8'h3c;
        @(negedge clk) req = 0;
        @(negedge clk) rst_n = 0;
        @(negedge clk) check("sel_n", 1, sel_n);
        check("wr_n", 1, wr_n);
        check("drive", 0, doe);
        check("busy_rst", 0, busy);
        rst_n = 1;
        put(17'h0_0f0f, 8'hc3);
        check("again", 8'hc3, mem.store[17'h0_0f0f]);
        check("clash", 0, clash);
        $display("reset done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        @(negedge clk) rst_n = 1;
        t_single;
        t_back;
        t_reset;
        give_verdict;
    end
endmodule
`default_nettype wire
